// [verilog/touch_cmd_pkg.sv]
// Purpose: constants for the touch button command interpreter
// Assumes: byte-level transfer port from an i2c slave front end
// Notes:   offsets, command codes and the button count live here only
package touch_cmd_pkg;
  localparam logic [7:0] OFF_BUTTON_ENABLE = 8'h06;
  localparam logic [7:0] OFF_SCAN_SELECT   = 8'h81;
  localparam logic [7:0] OFF_SCAN_DATA     = 8'h82;
  localparam logic [7:0] OFF_SCAN_LAST     = 8'h87;
  localparam logic [7:0] OFF_BUTTON_STATUS = 8'h88;
  localparam logic [7:0] OFF_COMMAND       = 8'hA0;
  localparam logic [7:0] CMD_SAVE_NV       = 8'h01;
  localparam logic [7:0] CMD_LOAD_DEFAULT  = 8'h02;
  localparam logic [7:0] CMD_SOFT_RESET    = 8'h06;
  localparam logic [7:0] CMD_NORMAL_MODE   = 8'h07;
  localparam logic [7:0] CMD_SETUP_MODE    = 8'h08;
  localparam logic [7:0] RST_BUTTON_ENABLE = 8'h00;
  localparam logic [7:0] RST_SCAN_SELECT   = 8'h01;
  localparam logic [7:0] DEFAULT_ENABLE    = 8'h00;
  localparam logic [7:0] RD_ZERO           = 8'h00;
  localparam logic [1:0] SLEEP_512HZ       = 2'h1;
  localparam logic [1:0] SLEEP_64HZ        = 2'h2;
  localparam int         NUM_BUTTONS       = 8;
endpackage : touch_cmd_pkg

// [verilog/touch_button_host_commands.sv]
// Purpose: command register and scan result window of a touch button chip
// Assumes: an i2c slave front end delivers start, address-match and bytes
// Notes:   state is one packed struct; all outputs come from flip-flops
// Operation
// - code 08 enters setup; reset needs setup
// - code 07 returns to normal mode
// - code 02 loads factory defaults into ram
// - code 01 saves working config to nonvolatile
// - save fails at 512 or 64 hz sleep
// - button enable write only in setup mode
// - one-hot select at 81 picks scan button
// - offset-only write sets the read pointer
// - six bytes from 82 give scan words
// - read at 88 returns button status
// - transfer is address, offset, then data bytes
`timescale 1ns/100ps
module touch_button_host_commands
  import touch_cmd_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  input  wire logic                   xfer_start,
  input  wire logic                   wr_valid,
  input  wire logic [7:0]             wr_byte,
  input  wire logic                   rd_req,
  input  wire logic [1:0]             sleep_rate,
  input  wire logic                   nv_busy,
  input  wire logic [NUM_BUTTONS-1:0] touch_state,
  input  wire logic [15:0]            baseline_in,
  input  wire logic [15:0]            diff_count_in,
  input  wire logic [15:0]            raw_count_in,
  output logic      [7:0]             rd_byte,
  output logic                        rd_valid,
  output logic                        setup_mode,
  output logic      [7:0]             button_enable,
  output logic      [7:0]             scan_select,
  output logic                        nv_save_pulse,
  output logic                        nv_save_fail,
  output logic                        soft_reset_pulse
);
  typedef enum logic [2:0] {
    PH_IDLE   = 3'b001,
    PH_OFFSET = 3'b010,
    PH_DATA   = 3'b100
  } phase_e;

  typedef struct packed {
    phase_e     phase;
    logic [7:0] ptr;
    logic       setup;
    logic [7:0] enable;
    logic [7:0] select;
    logic [7:0] rdata;
    logic       rvalid;
    logic       save;
    logic       fail;
    logic       srst;
  } state_s;

  state_s cur_q;
  state_s nxt_d;

  // byte of the scan window for a pointer in 82..87, msb first
  function automatic logic [7:0] scan_byte(input logic [7:0] p,
      input logic [15:0] b, input logic [15:0] d, input logic [15:0] r);
    logic [7:0] idx;
    idx = p - OFF_SCAN_DATA;
    case (idx)
      8'h00:   scan_byte = b[15:8];
      8'h01:   scan_byte = b[7:0];
      8'h02:   scan_byte = d[15:8];
      8'h03:   scan_byte = d[7:0];
      8'h04:   scan_byte = r[15:8];
      8'h05:   scan_byte = r[7:0];
      default: scan_byte = RD_ZERO;
    endcase
  endfunction : scan_byte

  // read decode; unmapped or write-only offsets read zero
  function automatic logic [7:0] read_mux(input state_s s,
      input logic [NUM_BUTTONS-1:0] t, input logic [15:0] b,
      input logic [15:0] d, input logic [15:0] r);
    if (s.ptr == OFF_BUTTON_ENABLE)
      read_mux = s.enable;
    else if (s.ptr == OFF_SCAN_SELECT)
      read_mux = s.select;
    else if (s.ptr >= OFF_SCAN_DATA && s.ptr <= OFF_SCAN_LAST)
      read_mux = scan_byte(s.ptr, b, d, r);
    else if (s.ptr == OFF_BUTTON_STATUS)
      read_mux = t;
    else
      read_mux = RD_ZERO;
  endfunction : read_mux

  // transfer sequencing, register writes and command decode
  always_comb begin
    nxt_d        = cur_q;
    nxt_d.rvalid = 1'b0;
    nxt_d.save   = 1'b0;
    nxt_d.srst   = 1'b0;
    if (xfer_start) begin
      nxt_d.phase = PH_OFFSET;
    end else if (wr_valid) begin
      case (cur_q.phase)
        PH_OFFSET: begin
          nxt_d.ptr   = wr_byte;
          nxt_d.phase = PH_DATA;
        end
        PH_DATA: begin
          nxt_d.ptr = cur_q.ptr + 8'h01;
          case (cur_q.ptr)
            OFF_BUTTON_ENABLE: begin
              // silently dropped outside setup mode
              if (cur_q.setup)
                nxt_d.enable = wr_byte;
            end
            OFF_SCAN_SELECT: nxt_d.select = wr_byte;
            OFF_COMMAND: begin
              case (wr_byte)
                CMD_SETUP_MODE:   nxt_d.setup = 1'b1;
                CMD_NORMAL_MODE:  nxt_d.setup = 1'b0;
                CMD_LOAD_DEFAULT: nxt_d.enable = DEFAULT_ENABLE;
                CMD_SAVE_NV: begin
                  // a save while one runs is the host's fault; dropped
                  if (!nv_busy) begin
                    if (sleep_rate == SLEEP_512HZ ||
                        sleep_rate == SLEEP_64HZ)
                      nxt_d.fail = 1'b1;
                    else begin
                      nxt_d.save = 1'b1;
                      nxt_d.fail = 1'b0;
                    end
                  end
                end
                CMD_SOFT_RESET: begin
                  if (cur_q.setup) begin
                    nxt_d.srst   = 1'b1;
                    nxt_d.setup  = 1'b0;
                    nxt_d.select = RST_SCAN_SELECT;
                  end
                end
                default: ;
              endcase
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end else if (rd_req) begin
      nxt_d.rdata  = read_mux(cur_q, touch_state, baseline_in,
                              diff_count_in, raw_count_in);
      nxt_d.rvalid = 1'b1;
      nxt_d.ptr    = cur_q.ptr + 8'h01;
      nxt_d.phase  = PH_IDLE;
    end
  end

  // single state register, frozen while clk_en is low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_q.phase  <= PH_IDLE;
      cur_q.ptr    <= RD_ZERO;
      cur_q.setup  <= 1'b0;
      cur_q.enable <= RST_BUTTON_ENABLE;
      cur_q.select <= RST_SCAN_SELECT;
      cur_q.rdata  <= RD_ZERO;
      cur_q.rvalid <= 1'b0;
      cur_q.save   <= 1'b0;
      cur_q.fail   <= 1'b0;
      cur_q.srst   <= 1'b0;
    end else if (clk_en) begin
      cur_q <= nxt_d;
    end
  end

  assign rd_byte          = cur_q.rdata;
  assign rd_valid         = cur_q.rvalid;
  assign setup_mode       = cur_q.setup;
  assign button_enable    = cur_q.enable;
  assign scan_select      = cur_q.select;
  assign nv_save_pulse    = cur_q.save;
  assign nv_save_fail     = cur_q.fail;
  assign soft_reset_pulse = cur_q.srst;

  // load-default may rewrite the enable in either mode; only writes gated
  a_enable_setup_only: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && !cur_q.setup && !(wr_valid && !xfer_start
      && cur_q.phase == PH_DATA && cur_q.ptr == OFF_COMMAND
      && wr_byte == CMD_LOAD_DEFAULT)) |=> $stable(button_enable))
    else $error("button enable changed outside setup mode");

  a_reset_needs_setup: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    soft_reset_pulse |-> !setup_mode && $past(setup_mode))
    else $error("soft reset issued without setup mode");

  a_save_not_slow: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    nv_save_pulse |-> $past(sleep_rate) != SLEEP_512HZ
                   && $past(sleep_rate) != SLEEP_64HZ)
    else $error("save issued at forbidden sleep rate");

  a_read_advances: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_req && !wr_valid && !xfer_start)
      |=> rd_valid && cur_q.ptr == $past(cur_q.ptr) + 8'h01)
    else $error("read pointer did not advance");

  a_offset_sets_ptr: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && wr_valid && !xfer_start && cur_q.phase == PH_OFFSET)
      |=> cur_q.ptr == $past(wr_byte) && cur_q.phase == PH_DATA)
    else $error("offset byte did not load read pointer");

  a_status_read: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_req && !wr_valid && !xfer_start
      && cur_q.ptr == OFF_BUTTON_STATUS) |=> rd_byte == $past(touch_state))
    else $error("status read returned wrong byte");

  a_normal_cmd: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && wr_valid && !xfer_start && cur_q.phase == PH_DATA
      && cur_q.ptr == OFF_COMMAND && wr_byte == CMD_NORMAL_MODE)
      |=> !setup_mode)
    else $error("normal mode command ignored");

  a_setup_cmd: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && wr_valid && !xfer_start && cur_q.phase == PH_DATA
      && cur_q.ptr == OFF_COMMAND && wr_byte == CMD_SETUP_MODE)
      |=> setup_mode)
    else $error("setup mode command ignored");

  a_select_write: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && wr_valid && !xfer_start && cur_q.phase == PH_DATA
      && cur_q.ptr == OFF_SCAN_SELECT) |=> scan_select == $past(wr_byte))
    else $error("scan select not written");
endmodule : touch_button_host_commands

// [tb/host_model.sv]
// Purpose: host byte front end and nonvolatile store stand-in
// Assumes: every strobe lasts one ref_clk cycle, then one idle cycle
// Notes:   store stays busy for BUSY_CYC cycles after each save pulse
`timescale 1ns/100ps
module host_model #(
  parameter int BUSY_CYC = 20
) (
  input  wire logic       ref_clk,
  input  wire logic       nv_save_pulse,
  output logic            xfer_start,
  output logic            wr_valid,
  output logic      [7:0] wr_byte,
  output logic            rd_req,
  output logic            nv_busy
);
  int busy_cnt = 0;

  initial begin
    xfer_start = 1'b0;
    wr_valid   = 1'b0;
    wr_byte    = 8'h00;
    rd_req     = 1'b0;
  end

  // store busy window; the host may not command until it ends
  always @(posedge ref_clk) begin
    if (nv_save_pulse === 1'b1) busy_cnt <= BUSY_CYC;
    else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
  end
  assign nv_busy = (busy_cnt != 0);

  // one strobe; released byte lines show the inverse, not a stale value
  task automatic put(input logic s, input logic w, input logic r,
                     input logic [7:0] b);
    @(posedge ref_clk);
    xfer_start <= s;
    wr_valid   <= w;
    rd_req     <= r;
    wr_byte    <= b;
    @(posedge ref_clk);
    xfer_start <= 1'b0;
    wr_valid   <= 1'b0;
    rd_req     <= 1'b0;
    wr_byte    <= ~b;
  endtask : put
endmodule : host_model

// [tb/touch_button_host_commands_tb_top.sv]
// Purpose: self-checking bench for the touch button command block
// Assumes: host_model drives the byte port, reads checked from a queue
// Notes:   scan words and touch bits are random from a fixed seed
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
  error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module touch_button_host_commands_tb_top;
  import touch_cmd_pkg::*;
  logic                   ref_clk = 1'b0;
  logic                   sys_rst, clk_en, wr_valid, rd_req, xfer_start;
  logic                   nv_busy, rd_valid, setup_mode, nv_save_pulse;
  logic                   nv_save_fail, soft_reset_pulse;
  logic [1:0]             sleep_rate;
  logic [7:0]             wr_byte, rd_byte, button_enable, scan_select;
  logic [NUM_BUTTONS-1:0] touch_state;
  logic [15:0]            bl, dl, rw;
  logic [47:0]            scan_w;
  logic [7:0]             exp_b, touch_w;
  logic [7:0]             exp_q[$];
  int                     error_cnt = 0, compares = 0, seed = 37;
  int                     save_cnt = 0, srst_cnt = 0;

  always #2 ref_clk = ~ref_clk;

  touch_button_host_commands uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .xfer_start(xfer_start), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .rd_req(rd_req), .sleep_rate(sleep_rate),
    .nv_busy(nv_busy), .touch_state(touch_state), .baseline_in(bl),
    .diff_count_in(dl), .raw_count_in(rw), .rd_byte(rd_byte),
    .rd_valid(rd_valid), .setup_mode(setup_mode),
    .button_enable(button_enable), .scan_select(scan_select),
    .nv_save_pulse(nv_save_pulse), .nv_save_fail(nv_save_fail),
    .soft_reset_pulse(soft_reset_pulse));
  host_model host (.ref_clk(ref_clk), .nv_save_pulse(nv_save_pulse),
    .xfer_start(xfer_start), .wr_valid(wr_valid), .wr_byte(wr_byte),
    .rd_req(rd_req), .nv_busy(nv_busy));

  // read monitor takes the oldest note whenever a byte appears
  always @(posedge ref_clk) begin
    if (soft_reset_pulse === 1'b1) srst_cnt++;
    if (nv_save_pulse === 1'b1) save_cnt++;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK("rd_extra", 1'b0, 1'b1)
      else begin
        // pop once; the macro names its expected value twice
        exp_b = exp_q.pop_front();
        `CHK("rd_byte", exp_b, rd_byte)
      end
    end
  end

  task automatic conclude();
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // one write transfer: start, offset, data; outputs settle after 2 edges
  task automatic cmd(input logic [7:0] off, input logic [7:0] d);
    host.put(1'b1, 1'b0, 1'b0, 8'h00);
    host.put(1'b0, 1'b1, 1'b0, off);
    host.put(1'b0, 1'b1, 1'b0, d);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : cmd

  // offset-only write sets the pointer, then n reads
  task automatic rd(input logic [7:0] off, input int n);
    host.put(1'b1, 1'b0, 1'b0, 8'h00);
    host.put(1'b0, 1'b1, 1'b0, off);
    repeat (n) host.put(1'b0, 1'b0, 1'b1, 8'h00);
    repeat (3) @(posedge ref_clk);
  endtask : rd

  initial begin
    #20000;
    error_cnt++;
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    sleep_rate = 2'h0;
    touch_state = '0;
    bl = 16'h0000;
    dl = 16'h0000;
    rw = 16'h0000;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("setup", 1'b0, setup_mode)
    `CHK("sel", RST_SCAN_SELECT, scan_select)
    cmd(OFF_BUTTON_ENABLE, 8'h01);
    `CHK("en", RST_BUTTON_ENABLE, button_enable)
    cmd(OFF_COMMAND, CMD_SOFT_RESET);
    `CHK("srst", 0, srst_cnt)
    cmd(OFF_COMMAND, CMD_SETUP_MODE);
    `CHK("setup", 1'b1, setup_mode)
    cmd(OFF_BUTTON_ENABLE, 8'h01);
    `CHK("en", 8'h01, button_enable)
    cmd(OFF_COMMAND, 8'h55);
    `CHK("setup", 1'b1, setup_mode)
    `CHK("en", 8'h01, button_enable)
    for (int i = 0; i < 2; i++) begin
      sleep_rate <= (i == 0) ? SLEEP_512HZ : SLEEP_64HZ;
      cmd(OFF_COMMAND, CMD_SAVE_NV);
      `CHK("fail", 1'b1, nv_save_fail)
      `CHK("save", 0, save_cnt)
    end
    sleep_rate <= 2'h0;
    cmd(OFF_COMMAND, CMD_SAVE_NV);
    `CHK("save", 1, save_cnt)
    `CHK("fail", 1'b0, nv_save_fail)
    for (int i = 0; i < 100 && nv_busy; i++) @(posedge ref_clk);
    `CHK("busy", 1'b0, nv_busy)
    cmd(OFF_COMMAND, CMD_LOAD_DEFAULT);
    `CHK("en", DEFAULT_ENABLE, button_enable)
    cmd(OFF_SCAN_SELECT, 8'h04);
    `CHK("sel", 8'h04, scan_select)
    // frozen clock enable must swallow a whole write transfer
    clk_en <= 1'b0;
    cmd(OFF_SCAN_SELECT, 8'h02);
    `CHK("sel", 8'h04, scan_select)
    clk_en <= 1'b1;
    repeat (2) begin
      scan_w  = {16'($random(seed)), 16'($random(seed)),
                 16'($random(seed))};
      touch_w = 8'($random(seed));
      {bl, dl, rw} <= scan_w;
      touch_state  <= touch_w;
      for (int i = 0; i < 6; i++) exp_q.push_back(scan_w[47-8*i -: 8]);
      rd(OFF_SCAN_DATA, 6);
      exp_q.push_back(touch_w);
      rd(OFF_BUTTON_STATUS, 1);
    end
    cmd(OFF_COMMAND, CMD_SOFT_RESET);
    `CHK("srst", 1, srst_cnt)
    `CHK("setup", 1'b0, setup_mode)
    `CHK("sel", RST_SCAN_SELECT, scan_select)
    cmd(OFF_COMMAND, CMD_SETUP_MODE);
    `CHK("setup", 1'b1, setup_mode)
    cmd(OFF_COMMAND, CMD_NORMAL_MODE);
    `CHK("setup", 1'b0, setup_mode)
    `CHK("pending", 0, exp_q.size())
    conclude();
  end
endmodule : touch_button_host_commands_tb_top
